//--- hdl/aiss_top.sv
// Overview of operation
// R1: Undervoltage flag bit 7 sets on recovery comparator assertion, clears on read.
// R2: Overtemperature flag bit 6 sets on overtemperature assertion, clears on read.
// R3: Mask bit 5, reset 0, hides undervoltage from interrupt pin.
// R4: Mask bit 4, reset 1, hides overtemperature from interrupt pin.
// R5: Bit 3 shows live undervoltage state, reset 0, unaffected by read.
// R6: Bit 2 shows live overtemperature state, separate from latched flag.
// R7: Bit 1, reset 0, enables output select switch.
// R8: Bit 0, reset 0, enables link switch between regulator and buck-boost.
// R9: Shutdown bits 7..2 turn selected switches off during an interruption; code forces them off only while an unmasked alarm is live.
// R10: Shutdown select reset values 1,0,1,1,1,0 from bit 7 down.
// R11: Shutdown bit 1, reset 1, turns link switch off during interruption; code turns it off only while an unmasked alarm is live.
// R12: Shutdown bit 0, reset 1, disables the recovery comparator.
// R13: Interrupt pin follows undervoltage: asserts below falling, releases above rising.
// R14: Switch enable bits: 0 disabled, 1 enabled.
// R15: Alarm event coinciding with clearing read keeps its flag set.
// R16: Host reads the alarm register after each interrupt assertion.
`default_nettype none
module aiss_top
    import aiss_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic recovery_comparator,
    input wire logic overtemp_in,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic int_n,
    output logic [5:0] switch_force_off,
    output logic output_select_switch_en,
    output logic regulator_link_switch_en,
    output logic recovery_comparator_en
);
    // ****************************************
    // Input synchronisers
    // ****************************************
    logic uv_meta_ff, uv_sync_ff, ot_meta_ff, ot_sync_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            uv_meta_ff <= 1'b0;
            uv_sync_ff <= 1'b0;
            ot_meta_ff <= 1'b0;
            ot_sync_ff <= 1'b0;
        end else begin
            uv_meta_ff <= recovery_comparator;
            uv_sync_ff <= uv_meta_ff;
            ot_meta_ff <= overtemp_in;
            ot_sync_ff <= ot_meta_ff;
        end
    end

    // ****************************************
    // Address decode
    // ****************************************
    // One compare shared by every strobe
    // Keeps write and read decode from drifting apart
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
        return addr == target;
    endfunction

    // ****************************************
    // Control registers
    // ****************************************
    logic undervoltage_alarm_mask_ff, overtemp_alarm_mask_ff;
    logic output_select_switch_on_ff, link_switch_on_ff;
    logic [5:0] switch_auto_off_ff;
    logic link_switch_auto_off_ff, recovery_comparator_off_ff;
    logic wr_alarm, wr_shut, rd_alarm;

    assign wr_alarm = reg_wr && addr_hit(reg_addr, ALARM_FLAGS_AND_LINK_SWITCH_ADDR);
    assign wr_shut = reg_wr && addr_hit(reg_addr, INTERRUPTION_SWITCH_SHUTDOWN_ADDR);
    assign rd_alarm = reg_rd && addr_hit(reg_addr, ALARM_FLAGS_AND_LINK_SWITCH_ADDR);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            undervoltage_alarm_mask_ff <= UV_MASK_RST; // R3
            overtemp_alarm_mask_ff <= OT_MASK_RST; // R4
            output_select_switch_on_ff <= SEL_SW_RST; // R7
            link_switch_on_ff <= LINK_SW_RST; // R8
        end else if (wr_alarm) begin
            undervoltage_alarm_mask_ff <= reg_wdata[UV_MASK_BIT]; // R3
            overtemp_alarm_mask_ff <= reg_wdata[OT_MASK_BIT]; // R4
            output_select_switch_on_ff <= reg_wdata[SEL_SW_BIT]; // R7 R14
            link_switch_on_ff <= reg_wdata[LINK_SW_BIT]; // R8 R14
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            switch_auto_off_ff <= SW_AUTO_OFF_RST; // R10
            link_switch_auto_off_ff <= LINK_OFF_RST; // R11
            recovery_comparator_off_ff <= COMP_OFF_RST; // R12
        end else if (wr_shut) begin
            switch_auto_off_ff <= reg_wdata[SW_SEL_MSB:SW_SEL_LSB]; // R9
            link_switch_auto_off_ff <= reg_wdata[LINK_OFF_BIT]; // R11
            recovery_comparator_off_ff <= reg_wdata[COMP_OFF_BIT]; // R12
        end
    end

    // ****************************************
    // Live state and latched alarms
    // ****************************************
    // Comparator output is ignored while it is powered down
    logic undervoltage_live_state_ff, overtemp_live_state_ff;
    logic undervoltage_alarm_flag_ff, overtemp_alarm_flag_ff;
    logic uv_live, uv_event, ot_event;

    assign uv_live = uv_sync_ff && !recovery_comparator_off_ff; // R12
    assign uv_event = uv_live && !undervoltage_live_state_ff;
    assign ot_event = ot_sync_ff && !overtemp_live_state_ff;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            undervoltage_live_state_ff <= 1'b0;
            overtemp_live_state_ff <= 1'b0;
        end else begin
            undervoltage_live_state_ff <= uv_live; // R5
            overtemp_live_state_ff <= ot_sync_ff; // R6
        end
    end

    // Set has priority so an event during a clearing read survives
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            undervoltage_alarm_flag_ff <= 1'b0;
            overtemp_alarm_flag_ff <= 1'b0;
        end else begin
            if (uv_event)
                undervoltage_alarm_flag_ff <= 1'b1; // R1 R15
            else if (rd_alarm)
                undervoltage_alarm_flag_ff <= 1'b0; // R1
            if (ot_event)
                overtemp_alarm_flag_ff <= 1'b1; // R2 R15
            else if (rd_alarm)
                overtemp_alarm_flag_ff <= 1'b0; // R2
        end
    end

    // ****************************************
    // Read data
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                ALARM_FLAGS_AND_LINK_SWITCH_ADDR: begin
                    reg_rdata <= {undervoltage_alarm_flag_ff, overtemp_alarm_flag_ff,
                                  undervoltage_alarm_mask_ff, overtemp_alarm_mask_ff,
                                  undervoltage_live_state_ff, overtemp_live_state_ff, // R5 R6
                                  output_select_switch_on_ff, link_switch_on_ff};
                end
                INTERRUPTION_SWITCH_SHUTDOWN_ADDR: begin
                    reg_rdata <= {switch_auto_off_ff, link_switch_auto_off_ff, recovery_comparator_off_ff};
                end
                default: begin
                    reg_rdata <= 8'h00;
                end
            endcase
        end
    end

    // ****************************************
    // Interrupt pin and switch shutdown
    // ****************************************
    // Pin tracks live faults, not flags, so it releases on recovery
    logic int_active;
    assign int_active = (undervoltage_live_state_ff && !undervoltage_alarm_mask_ff) // R3 R13
                      || (overtemp_live_state_ff && !overtemp_alarm_mask_ff); // R4

    // Registered so the pin never glitches on decode
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !int_active; // R13
        end
    end

    // One gate per switch; a clear select leaves that switch alone
    wire [NUM_SW-1:0] nxt_switch_force_off;
    genvar sw_idx;
    generate
        for (sw_idx = 0; sw_idx < NUM_SW; sw_idx = sw_idx + 1) begin : g_switch_off
            assign nxt_switch_force_off[sw_idx] = int_active && switch_auto_off_ff[sw_idx]; // R9
        end
    endgenerate

    // Force released as soon as the fault clears
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            switch_force_off <= 6'h00;
        end else begin
            switch_force_off <= nxt_switch_force_off; // R9
        end
    end

    // Shutdown touches only the link; the select switch keeps its setting
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            output_select_switch_en <= 1'b0;
            regulator_link_switch_en <= 1'b0;
        end else begin
            output_select_switch_en <= output_select_switch_on_ff; // R7
            regulator_link_switch_en <= link_switch_on_ff && !(int_active && link_switch_auto_off_ff); // R8 R11
        end
    end

    // Comparator powered down by default to save supply current
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            recovery_comparator_en <= 1'b0;
        end else begin
            recovery_comparator_en <= !recovery_comparator_off_ff; // R12
        end
    end
endmodule
`default_nettype wire

//--- hdl/aiss_pkg.sv
`default_nettype none
package aiss_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [7:0] ALARM_FLAGS_AND_LINK_SWITCH_ADDR = 8'h07;
    localparam logic [7:0] INTERRUPTION_SWITCH_SHUTDOWN_ADDR = 8'h08;

    // ****************************************
    // Alarm register fields
    // ****************************************
    localparam int UV_FLAG_BIT = 7;
    localparam int OT_FLAG_BIT = 6;
    localparam int UV_MASK_BIT = 5;
    localparam int OT_MASK_BIT = 4;
    localparam int UV_LIVE_BIT = 3;
    localparam int OT_LIVE_BIT = 2;
    localparam int SEL_SW_BIT = 1;
    localparam int LINK_SW_BIT = 0;

    // ****************************************
    // Shutdown register fields
    // ****************************************
    localparam int SW_SEL_MSB = 7;
    localparam int SW_SEL_LSB = 2;
    localparam int NUM_SW = 6;
    localparam int LINK_OFF_BIT = 1;
    localparam int COMP_OFF_BIT = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic UV_MASK_RST = 1'b0;
    localparam logic OT_MASK_RST = 1'b1;
    localparam logic SEL_SW_RST = 1'b0;
    localparam logic LINK_SW_RST = 1'b0;
    // Order: battery, boost b, regulator b, regulator a, auxiliary, boost a
    localparam logic [5:0] SW_AUTO_OFF_RST = 6'h2e;
    localparam logic LINK_OFF_RST = 1'b1;
    localparam logic COMP_OFF_RST = 1'b1;
endpackage
`default_nettype wire

//--- test/aiss_top_assertions.sv
`default_nettype none
module aiss_top_assertions (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic recovery_comparator,
    input wire logic overtemp_in,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic int_n,
    input wire logic [5:0] switch_force_off,
    input wire logic output_select_switch_en,
    input wire logic regulator_link_switch_en,
    input wire logic recovery_comparator_en
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    a_rdata_hold: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("read data moved");
    a_sel_mirror: assert property (reg_wr && reg_addr == 8'h07 |-> ##2 output_select_switch_en == $past(reg_wdata[1], 2))
        else $error("select switch wrong");
    a_comp_off: assert property (reg_wr && reg_addr == 8'h08 && reg_wdata[0] |-> ##2 !recovery_comparator_en)
        else $error("comparator not off");
    a_int_release: assert property ((!recovery_comparator && !overtemp_in) [*5] |=> int_n)
        else $error("interrupt not released");
    a_force_clear: assert property ((!recovery_comparator && !overtemp_in) [*5] |=> switch_force_off == 6'h00)
        else $error("switch still forced off");
    a_live_idle: assert property ((!recovery_comparator && !overtemp_in) [*5] ##0 (reg_rd && reg_addr == 8'h07)
        |=> reg_rdata[3:2] == 2'b00)
        else $error("live state set");
    a_link_readback: assert property ((!recovery_comparator && !overtemp_in) [*5] ##0 (reg_rd && reg_addr == 8'h07)
        |=> reg_rdata[0] == regulator_link_switch_en)
        else $error("link switch mismatch");
    a_comp_readback: assert property (reg_rd && reg_addr == 8'h08 |=> reg_rdata[0] == !recovery_comparator_en)
        else $error("comparator enable mismatch");
endmodule
bind aiss_top aiss_top_assertions u_aiss_top_assertions (.*);
`default_nettype wire

//--- test/aiss_host_model.sv
`default_nettype none
module aiss_host_model (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // Released lines show inverted values, never the stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // Used after each interrupt to learn the cause and clear flags
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        // Read data stands until the next read strobe
        @(posedge clk_sys);
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

//--- test/aiss_top_bench.sv
`default_nettype none
module aiss_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, recovery_comparator, overtemp_in, reg_wr, reg_rd, int_n;
    logic output_select_switch_en, regulator_link_switch_en, recovery_comparator_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, w7, w8;
    logic [5:0] switch_force_off;
    int n_errors = 0;
    int num_checks = 0;
    aiss_top u_aiss_top (.*);
    aiss_host_model u_aiss_host_model (.*);
    function automatic logic [7:0] exp7(logic [7:0] w, logic [3:0] st);
        return {st[3:2], w[5:4], st[1:0], w[1:0]};
    endfunction
    task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic rd7(logic [7:0] e);
        u_aiss_host_model.rd(8'h07, d);
        chk("reg7", d, e);
    endtask
    task automatic settle();
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #40000;
        n_errors++;
        conclude();
    end
    initial begin
        rst_n = 1'b0;
        recovery_comparator = 1'b0;
        overtemp_in = 1'b0;
        void'($urandom(32'he428c95d));
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1 chk("int", int_n, 1);
        chk("off", switch_force_off, 0);
        chk("en", {output_select_switch_en, regulator_link_switch_en, recovery_comparator_en}, 0);
        rd7(8'h10);
        u_aiss_host_model.rd(8'h08, d);
        chk("reg8", d, 8'hbb);
        // Comparator starts disabled, so a fault is ignored
        recovery_comparator <= 1'b1;
        settle();
        chk("int", int_n, 1);
        rd7(8'h10);
        recovery_comparator <= 1'b0;
        u_aiss_host_model.wr(8'h09, 8'hff);
        u_aiss_host_model.rd(8'h08, d);
        chk("reg8", d, 8'hbb);
        u_aiss_host_model.rd(8'h09, d);
        chk("unmapped", d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            w7 = 8'($urandom);
            w8 = 8'($urandom);
            u_aiss_host_model.wr(8'h07, w7);
            u_aiss_host_model.wr(8'h08, w8);
            rd7(exp7(w7, 0));
            u_aiss_host_model.rd(8'h08, d);
            chk("reg8", d, w8);
            #1;
            chk("sel", output_select_switch_en, w7[1]);
            chk("link", regulator_link_switch_en, w7[0]);
            chk("comp", recovery_comparator_en, !w8[0]);
            chk("off", switch_force_off, 0);
            chk("int", int_n, 1);
        end
        w7 = 8'($urandom) & 8'h03;
        w8 = 8'($urandom) & 8'hfe;
        u_aiss_host_model.wr(8'h07, w7);
        u_aiss_host_model.wr(8'h08, w8);
        recovery_comparator <= 1'b1;
        settle();
        chk("int", int_n, 0);
        chk("off", switch_force_off, w8[7:2]);
        chk("link", regulator_link_switch_en, w7[0] & ~w8[1]);
        rd7(exp7(w7, 4'b1010));
        rd7(exp7(w7, 4'b0010));
        recovery_comparator <= 1'b0;
        settle();
        chk("int", int_n, 1);
        u_aiss_host_model.wr(8'h07, w7 | 8'h10);
        overtemp_in <= 1'b1;
        // Read lands on the edge that raises the flag
        @(posedge clk_sys);
        u_aiss_host_model.rd(8'h07, d);
        chk("reg7", d, exp7(w7 | 8'h10, 4'b0000));
        rd7(exp7(w7 | 8'h10, 4'b0101));
        settle();
        chk("int", int_n, 1);
        u_aiss_host_model.wr(8'h07, w7);
        settle();
        chk("int", int_n, 0);
        rd7(exp7(w7, 4'b0001));
        overtemp_in <= 1'b0;
        u_aiss_host_model.wr(8'h07, w7 | 8'h20);
        recovery_comparator <= 1'b1;
        settle();
        chk("int", int_n, 1);
        conclude();
    end
endmodule
`default_nettype wire
